// File: hw/sld_pkg.sv
/*
  Package of the serial line discipline: character codes, defaults,
  carrier structs and the state encoding of the line editor.
  Assumes a byte-wide receiver and transmitter on the same clock.
*/
package sld_pkg;

  // ==========================================================
  // Character codes
  localparam logic [7:0] SLD_CH_CR    = 8'h0D;
  localparam logic [7:0] SLD_CH_LF    = 8'h0A;
  localparam logic [7:0] SLD_CH_BS    = 8'h08;
  localparam logic [7:0] SLD_CH_ESC   = 8'h1B;
  localparam logic [7:0] SLD_CH_XON   = 8'h11;
  localparam logic [7:0] SLD_CH_XOFF  = 8'h13;
  localparam logic [7:0] SLD_CH_CAN   = 8'h18;
  localparam logic [7:0] SLD_CH_NAK   = 8'h15;
  localparam logic [7:0] SLD_CH_SP    = 8'h20;
  localparam logic [7:0] SLD_CH_BANG  = 8'h21;
  localparam logic [7:0] SLD_CH_GT    = 8'h3E;
  localparam logic [7:0] SLD_CTRL_MAX = 8'h1F;

  // ==========================================================
  // Sizes, error code and configuration defaults
  localparam int          SLD_DATA_W    = 8;
  localparam int          SLD_FIFO_DEPTH = 16;
  localparam int          SLD_SEQ_LEN   = 8;
  localparam logic [15:0] SLD_QOE_CODE  = 16'hFE70;  // -400
  localparam logic        SLD_RST_FLOW  = 1'b1;
  localparam logic        SLD_RST_ECHO  = 1'b0;
  localparam logic        SLD_RST_PROMPT = 1'b0;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sld_byte_s;

  typedef struct packed {
    logic flow;
    logic echo;
    logic prompt;
  } sld_cfg_s;

  typedef enum logic [1:0] {
    SLD_INIT  = 2'b00,
    SLD_IDLE  = 2'b01,
    SLD_PARSE = 2'b10
  } sld_phase_e;

endpackage

// File: hw/sld_fifo.sv
/*
  Input line buffer: FIFO with registered read data, flush, and a
  drop-last port for line editing.
  Assumes one clock and a synchronous active-high reset.
*/
module sld_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         flush,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  input  wire logic         unpush,
  input  wire logic         rd_en,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    ov;
    logic [W-1:0]            od;
  } sld_fifo_s;

  sld_fifo_s s_r;
  sld_fifo_s s_nxt;
  logic      load;

  // ==========================================================
  // Flags and outputs
  assign in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = s_r.ov;
  assign out_data  = s_r.od;
  assign load = rd_en && (s_r.cnt != '0) && (!s_r.ov || out_ready);

  // Next state: read into output register, write, or drop last
  always_comb begin
    s_nxt = s_r;
    if (s_r.ov && out_ready) begin
      s_nxt.ov = 1'b0;
    end
    if (load) begin
      s_nxt.od  = s_r.mem[s_r.rp];
      s_nxt.ov  = 1'b1;
      s_nxt.rp  = s_r.rp + 1'b1;
      s_nxt.cnt = s_nxt.cnt - 1'b1;
    end
    if (in_valid && in_ready) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp  = s_r.wp + 1'b1;
      s_nxt.cnt = s_nxt.cnt + 1'b1;
    end else if (unpush && (s_r.cnt != '0) && !load) begin
      s_nxt.wp  = s_r.wp - 1'b1;
      s_nxt.cnt = s_nxt.cnt - 1'b1;
    end
    if (flush) begin
      s_nxt.wp  = '0;
      s_nxt.rp  = '0;
      s_nxt.cnt = '0;
      s_nxt.ov  = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // sld_fifo

// File: hw/sld_core.sv
/*
  Serial line discipline: line editing, flow control, echo, prompt
  and queue-overflow signalling between a byte receiver/transmitter
  and a command parser. Assumes all ports on clk.
*/
// Function
// - CR or LF ends the line and hands the buffer to the parser.
// - ESC empties the input buffer, then CR LF is sent.
// - BS drops the last stored byte unless the buffer is empty.
// - Only seven control codes act; other control codes are ignored.
// - After the line is parsed and dispatched, CR LF is sent.
// - With flow control on, XON resumes and XOFF halts transmission.
// - CAN resets receive and transmit pointers and clears both queues.
// - With flow control on, a received XOFF logs queue-overflow error -400.
// - XON after XOFF drains pending data, then sends one '!'.
// - Echo mode returns received bytes; printable ones unchanged.
// - Echo mode answers BS with BS, space, BS.
// - Of an adjacent CR LF or LF CR pair only the first counts.
// - With flow control a terminator is answered XOFF CR, or XOFF.
// - Lost echo bytes send NAK and log queue-overflow error.
// - Prompt mode sends CR LF '>' when the next command may come.
// - Flow control is on by default; echo and prompt are optional.
// - Default echo off, prompt off, flow control on.
module sld_core #(
  parameter int DEPTH = sld_pkg::SLD_FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire sld_pkg::sld_byte_s rx_in,
  output logic                   rx_ready,
  input  wire logic              cfg_wr,
  input  wire sld_pkg::sld_cfg_s cfg_in,
  output sld_pkg::sld_cfg_s      cfg_out,
  output logic                   line_pending,
  output sld_pkg::sld_byte_s     line_out,
  input  wire logic              line_ready,
  input  wire logic              parse_done,
  input  wire sld_pkg::sld_byte_s resp_in,
  output logic                   resp_ready,
  output sld_pkg::sld_byte_s     tx_out,
  input  wire logic              tx_ready,
  output logic                   qoe_pulse,
  output logic [15:0]            qoe_code,
  output logic                   cancel_pulse
);
  localparam int LEN = sld_pkg::SLD_SEQ_LEN;

  typedef struct packed {
    sld_pkg::sld_phase_e   phase;
    sld_pkg::sld_cfg_s     cfg;
    sld_pkg::sld_byte_s    tx;
    logic [LEN-1:0][7:0]   seq;
    logic [3:0]            seq_cnt;
    logic                  halt;
    logic                  bang;
    logic                  nak;
    logic                  prev_term;
    logic [7:0]            last_term;
    logic                  resp_rdy;
    logic                  rx_rdy;
    logic                  qoe;
    logic [15:0]           code;
    logic                  cancel;
    logic                  pend;
  } sld_state_s;

  sld_state_s st_r;
  sld_state_s st_nxt;

  // Buffer hookup
  logic       fifo_wr;
  logic       fifo_in_ready;
  logic       fifo_flush;
  logic       fifo_unpush;
  logic       acc;
  logic [7:0] rb;
  logic       is_term;
  logic       is_pair;

  // ==========================================================
  // Received byte classification
  function automatic logic term_f(input logic [7:0] c);
    return (c == sld_pkg::SLD_CH_CR) || (c == sld_pkg::SLD_CH_LF);
  endfunction

  assign acc     = rx_in.valid && st_r.rx_rdy;
  assign rb      = rx_in.data;
  assign is_term = term_f(rb);
  assign is_pair = is_term && st_r.prev_term && (rb != st_r.last_term);

  // ==========================================================
  // Input line buffer
  sld_fifo #(
    .W     (sld_pkg::SLD_DATA_W),
    .DEPTH (DEPTH)
  ) u_line (
    .clk       (clk),
    .srst      (srst),
    .flush     (fifo_flush),
    .in_valid  (fifo_wr),
    .in_data   (rb),
    .in_ready  (fifo_in_ready),
    .unpush    (fifo_unpush),
    .rd_en     (st_r.phase == sld_pkg::SLD_PARSE),
    .out_valid (line_out.valid),
    .out_data  (line_out.data),
    .out_ready (line_ready)
  );

  // ==========================================================
  // Line editor, flow control and transmit sequencing
  always_comb begin
    logic [3:0][7:0] pb;
    logic [2:0]      pn;
    logic            idle;
    st_nxt      = st_r;
    pb          = '0;
    pn          = '0;
    fifo_wr     = 1'b0;
    fifo_flush  = 1'b0;
    fifo_unpush = 1'b0;
    idle        = (st_r.phase == sld_pkg::SLD_IDLE);
    st_nxt.qoe    = 1'b0;
    st_nxt.cancel = 1'b0;
    st_nxt.rx_rdy = 1'b1;
    if (cfg_wr) begin
      st_nxt.cfg = cfg_in;
    end
    // Transmit slot: committed response first, then queued bytes
    if (st_r.tx.valid && tx_ready) begin
      st_nxt.tx.valid = 1'b0;
    end
    if (st_r.resp_rdy && resp_in.valid) begin
      st_nxt.tx = resp_in;
    end else if ((!st_r.tx.valid || tx_ready) && !st_r.halt) begin
      if (st_r.seq_cnt != '0) begin
        st_nxt.tx      = '{valid: 1'b1, data: st_r.seq[0]};
        st_nxt.seq     = st_r.seq >> 8;
        st_nxt.seq_cnt = st_r.seq_cnt - 1'b1;
      end else if (st_r.nak) begin
        st_nxt.tx  = '{valid: 1'b1, data: sld_pkg::SLD_CH_NAK};
        st_nxt.nak = 1'b0;
      end else if (st_r.bang && !resp_in.valid) begin
        st_nxt.tx   = '{valid: 1'b1, data: sld_pkg::SLD_CH_BANG};
        st_nxt.bang = 1'b0;
      end
    end
    // Startup: open the link for the host
    if (st_r.phase == sld_pkg::SLD_INIT) begin
      st_nxt.phase = sld_pkg::SLD_IDLE;
      if (st_r.cfg.flow) begin
        pb[0] = sld_pkg::SLD_CH_XON;
        pn    = 3'd1;
      end
    end
    // Parser finished: line terminator, prompt, reopen flow
    if (st_r.phase == sld_pkg::SLD_PARSE && parse_done) begin
      st_nxt.phase = sld_pkg::SLD_IDLE;
      pb[0] = sld_pkg::SLD_CH_CR;
      pb[1] = sld_pkg::SLD_CH_LF;
      pn    = 3'd2;
      if (st_r.cfg.prompt) begin
        pb[2] = sld_pkg::SLD_CH_GT;
        pn    = 3'd3;
      end
      if (st_r.cfg.flow) begin
        pb[pn[1:0]] = sld_pkg::SLD_CH_XON;
        pn          = pn + 3'd1;
      end
    end
    // Received byte
    if (acc) begin
      if (!is_term) begin
        st_nxt.prev_term = 1'b0;
      end
      if (rb == sld_pkg::SLD_CH_CAN) begin
        fifo_flush     = 1'b1;
        st_nxt.seq_cnt = '0;
        st_nxt.bang    = 1'b0;
        st_nxt.nak     = 1'b0;
        st_nxt.cancel  = 1'b1;
        st_nxt.phase   = sld_pkg::SLD_IDLE;
        pn             = '0;
      end else if (rb == sld_pkg::SLD_CH_XOFF) begin
        if (st_r.cfg.flow) begin
          st_nxt.halt = 1'b1;
          st_nxt.qoe  = 1'b1;
        end
      end else if (rb == sld_pkg::SLD_CH_XON) begin
        if (st_r.cfg.flow) begin
          st_nxt.halt = 1'b0;
          if (st_r.halt) begin
            st_nxt.bang = 1'b1;
          end
        end
      end else if (idle) begin
        if (is_term) begin
          if (!is_pair) begin
            fifo_wr          = 1'b1;
            st_nxt.phase     = sld_pkg::SLD_PARSE;
            st_nxt.prev_term = 1'b1;
            st_nxt.last_term = rb;
            if (st_r.cfg.flow) begin
              pb[0] = sld_pkg::SLD_CH_XOFF;
              pb[1] = sld_pkg::SLD_CH_CR;
              pn    = st_r.cfg.echo ? 3'd2 : 3'd1;
            end else if (st_r.cfg.echo) begin
              pb[0] = rb;
              pn    = 3'd1;
            end
          end else begin
            st_nxt.prev_term = 1'b0;
          end
        end else if (rb == sld_pkg::SLD_CH_ESC) begin
          fifo_flush = 1'b1;
          pb[0] = sld_pkg::SLD_CH_CR;
          pb[1] = sld_pkg::SLD_CH_LF;
          pn    = 3'd2;
        end else if (rb == sld_pkg::SLD_CH_BS) begin
          fifo_unpush = 1'b1;
          if (st_r.cfg.echo) begin
            pb[0] = sld_pkg::SLD_CH_BS;
            pb[1] = sld_pkg::SLD_CH_SP;
            pb[2] = sld_pkg::SLD_CH_BS;
            pn    = 3'd3;
          end
        end else if (rb > sld_pkg::SLD_CTRL_MAX) begin
          fifo_wr = 1'b1;
          if (!fifo_in_ready) begin
            st_nxt.qoe = 1'b1;
          end
          if (st_r.cfg.echo) begin
            pb[0] = rb;
            pn    = 3'd1;
          end
        end
      end
    end
    // Queue the answer bytes, or flag their loss
    if (pn != '0) begin
      if (5'(st_nxt.seq_cnt) + 5'(pn) > 5'(LEN)) begin
        st_nxt.nak = 1'b1;
        st_nxt.qoe = 1'b1;
      end else begin
        for (int i = 0; i < 4; i++) begin
          if (i < int'(pn)) begin
            st_nxt.seq[3'(st_nxt.seq_cnt + 4'(i))] = pb[i];
          end
        end
        st_nxt.seq_cnt = st_nxt.seq_cnt + 4'(pn);
      end
    end
    if (st_nxt.qoe) begin
      st_nxt.code = sld_pkg::SLD_QOE_CODE;
    end
    st_nxt.resp_rdy = !st_nxt.halt && !st_nxt.tx.valid &&
                      (st_nxt.seq_cnt == '0) && !st_nxt.nak;
    st_nxt.pend     = (st_nxt.phase == sld_pkg::SLD_PARSE);
  end

  // State register with documented defaults
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r            <= '0;
      st_r.phase      <= sld_pkg::SLD_INIT;
      st_r.cfg.flow   <= sld_pkg::SLD_RST_FLOW;
      st_r.cfg.echo   <= sld_pkg::SLD_RST_ECHO;
      st_r.cfg.prompt <= sld_pkg::SLD_RST_PROMPT;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign rx_ready     = st_r.rx_rdy;
  assign cfg_out      = st_r.cfg;
  assign line_pending = st_r.pend;
  assign resp_ready   = st_r.resp_rdy;
  assign tx_out       = st_r.tx;
  assign qoe_pulse    = st_r.qoe;
  assign qoe_code     = st_r.code;
  assign cancel_pulse = st_r.cancel;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_term_parse: assert property (acc && is_term && !is_pair &&
    st_r.phase == sld_pkg::SLD_IDLE |=> line_pending)
    else $error("terminator did not start parsing");
  a_xoff_halt: assert property (acc && rb == sld_pkg::SLD_CH_XOFF &&
    st_r.cfg.flow |=> st_r.halt && qoe_pulse &&
    qoe_code == sld_pkg::SLD_QOE_CODE)
    else $error("XOFF did not halt and log error");
  a_halt_quiet: assert property (st_r.halt && !tx_out.valid && !acc
    |=> !tx_out.valid)
    else $error("transmit while halted");
  a_can_clear: assert property (acc && rb == sld_pkg::SLD_CH_CAN
    |=> st_r.seq_cnt == '0 && cancel_pulse && !line_pending)
    else $error("cancel did not clear queues");
  a_esc_crlf: assert property (acc && rb == sld_pkg::SLD_CH_ESC &&
    st_r.phase == sld_pkg::SLD_IDLE && st_r.seq_cnt == '0 |=>
    st_r.seq_cnt == 4'd2 && st_r.seq[0] == sld_pkg::SLD_CH_CR &&
    st_r.seq[1] == sld_pkg::SLD_CH_LF)
    else $error("escape not answered with CR LF");
  a_bs_echo: assert property (acc && rb == sld_pkg::SLD_CH_BS &&
    st_r.cfg.echo && st_r.phase == sld_pkg::SLD_IDLE &&
    st_r.seq_cnt == '0 |=> st_r.seq_cnt == 4'd3 &&
    st_r.seq[1] == sld_pkg::SLD_CH_SP)
    else $error("backspace echo wrong");
  a_pair_skip: assert property (acc && is_pair &&
    st_r.phase == sld_pkg::SLD_IDLE |=> !line_pending)
    else $error("second terminator of pair acted");
  a_term_xoff: assert property (acc && is_term && !is_pair &&
    st_r.cfg.flow && st_r.phase == sld_pkg::SLD_IDLE &&
    st_r.seq_cnt == '0 |=> st_r.seq[0] == sld_pkg::SLD_CH_XOFF)
    else $error("terminator not answered with XOFF");
  a_done_crlf: assert property (parse_done && line_pending &&
    st_r.seq_cnt == '0 && !acc |=> st_r.seq[0] == sld_pkg::SLD_CH_CR
    && st_r.seq[1] == sld_pkg::SLD_CH_LF)
    else $error("no CR LF after parsing");
  a_bang_cause: assert property (tx_out.valid &&
    tx_out.data == sld_pkg::SLD_CH_BANG && !$past(tx_out.valid)
    |-> $past(st_r.bang) || $past(resp_ready))
    else $error("idle mark without XON");

  c_line: cover property (line_pending ##[1:40] !line_pending);
  c_flow: cover property (st_r.halt ##[1:20] st_r.bang);
  c_nak: cover property (tx_out.valid &&
    tx_out.data == sld_pkg::SLD_CH_NAK);

endmodule // sld_core

// File: tb/sld_host_model.sv
/*
  Host model: sends queued bytes to the line discipline, logs every
  byte it transmits and follows its flow control.
  Assumes the bench's clock; queues are filled by the bench.
*/
module sld_host_model (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic               stall,
  output sld_pkg::sld_byte_s      rx_in,
  input  wire logic               rx_ready,
  input  wire sld_pkg::sld_byte_s tx_out,
  output logic                    tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Send queue {bypass, byte} and log of received output
  logic [8:0] sendq[$];
  logic [7:0] got[$];
  logic       gate = 1'b1;
  logic       may_send = 1'b0;
  logic [8:0] nx;

  // Idle line shows the inverse of the last byte
  initial begin
    rx_in = '{1'b0, 8'hFF};
    tx_ready = 1'b1;
  end

  // Offer a byte, hold it until taken, then release the line
  always @(posedge clk) begin
    if (rx_in.valid && rx_ready)
      rx_in <= '{1'b0, ~rx_in.data};
    else if (!rx_in.valid && sendq.size() > 0 &&
             (sendq[0][8] || may_send || !gate)) begin
      nx = sendq.pop_front();
      rx_in <= '{1'b1, nx[7:0]};
    end
  end

  // Take output bytes, stalling when told, and track XON and XOFF
  always @(posedge clk) begin
    tx_ready <= !stall;
    if (srst)
      may_send <= 1'b0;
    else if (tx_out.valid && tx_ready) begin
      got.push_back(tx_out.data);
      if (tx_out.data == sld_pkg::SLD_CH_XON) may_send <= 1'b1;
      if (tx_out.data == sld_pkg::SLD_CH_XOFF) may_send <= 1'b0;
    end
  end
endmodule // sld_host_model

// File: tb/sld_core_test.sv
/*
  Self-checking bench of the line discipline with a host model.
  Assumes the design package and the host model are compiled first.
*/
module sld_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals and bench state
  logic               clk, srst, cfg_wr, line_ready, parse_done;
  logic               stall, stall_n, hold_stall, rx_ready, resp_ready;
  logic               line_pending, qoe_pulse, cancel_pulse;
  logic [15:0]        qoe_code;
  sld_pkg::sld_byte_s rx_in, line_out, resp_in, tx_out;
  sld_pkg::sld_cfg_s  cfg_in, cfg_out;
  logic [7:0]         lineq[$], respq[$];
  int                 err_count = 0, cmp_count = 0, seed = 24802;
  int                 qoe_cnt = 0, can_cnt = 0, n, q0;
  byte                c;
  bit                 found;
  string              s;

  sld_core #(.DEPTH(16)) sld_core_i (.clk(clk), .srst(srst),
    .rx_in(rx_in), .rx_ready(rx_ready), .cfg_wr(cfg_wr),
    .cfg_in(cfg_in), .cfg_out(cfg_out), .line_pending(line_pending),
    .line_out(line_out), .line_ready(line_ready),
    .parse_done(parse_done), .resp_in(resp_in),
    .resp_ready(resp_ready), .tx_out(tx_out), .tx_ready(stall_n),
    .qoe_pulse(qoe_pulse), .qoe_code(qoe_code),
    .cancel_pulse(cancel_pulse));
  sld_host_model sld_host_model_i (.clk(clk), .srst(srst),
    .stall(stall), .rx_in(rx_in), .rx_ready(rx_ready),
    .tx_out(tx_out), .tx_ready(stall_n));

  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Parser side: random acceptance, response feed, event counts
  always @(posedge clk) begin
    line_ready <= ($random(seed) & 1) != 0;
    stall <= hold_stall || (($random(seed) & 3) == 0);
    if (line_out.valid && line_ready) lineq.push_back(line_out.data);
    if (qoe_pulse) qoe_cnt++;
    if (cancel_pulse) can_cnt++;
    if (resp_in.valid && resp_ready)
      resp_in <= '{1'b0, ~resp_in.data};
    else if (!resp_in.valid && respq.size() > 0)
      resp_in <= '{1'b1, respq.pop_front()};
  end

  // ==========================================================
  // Tasks
  task chk(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task send(input string t, input bit f);
    for (int i = 0; i < t.len(); i++)
      sld_host_model_i.sendq.push_back({f, t[i]});
  endtask

  task check_tx(input string e);
    n = 0;
    while (sld_host_model_i.got.size() < e.len() && n < 3000) begin
      @(posedge clk);
      n++;
    end
    repeat (30) @(posedge clk);
    chk(sld_host_model_i.got.size() == e.len(), "tx byte count");
    for (int i = 0; i < e.len(); i++)
      if (i < sld_host_model_i.got.size())
        chk(sld_host_model_i.got[i] === e[i], "tx byte");
    sld_host_model_i.got.delete();
  endtask

  task check_line(input string e);
    n = 0;
    while (lineq.size() < e.len() && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(line_pending === 1'b1, "line pending");
    chk(lineq.size() == e.len(), "line length");
    for (int i = 0; i < e.len() && i < lineq.size(); i++)
      chk(lineq[i] === e[i], "line byte");
    lineq.delete();
    @(posedge clk) parse_done <= 1'b1;
    @(posedge clk) parse_done <= 1'b0;
    @(posedge clk);
    chk(line_pending === 1'b0, "line released");
  endtask

  task set_cfg(input logic [2:0] v);
    @(posedge clk) cfg_wr <= 1'b1;
    cfg_in <= v;
    @(posedge clk) cfg_wr <= 1'b0;
    sld_host_model_i.gate = v[2];
    repeat (2) @(posedge clk);
    chk(cfg_out === v, "config");
  endtask

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog
  initial begin
    #1200000;
    err_count++;
    $display("unexpected at %0t: watchdog", $time);
    report_and_stop;
  end

  // ==========================================================
  // Main sequence
  initial begin
    srst = 1'b1; cfg_wr = 1'b0; cfg_in = '0; line_ready = 1'b0;
    parse_done = 1'b0; stall = 1'b0; hold_stall = 1'b0; resp_in = '0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    chk(cfg_out === 3'b100, "default config");
    check_tx("\021");
    chk(rx_ready === 1'b1, "receiver open");
    $display("reset test done");
    for (int e = 0; e < 2; e++) begin
      set_cfg({1'b1, e[0], 1'b0});
      send("AB\015", 1'b0);
      check_tx(e ? "AB\023\015" : "\023");
      check_line("AB\015");
      check_tx("\015\012\021");
    end
    $display("terminator test done");
    q0 = qoe_cnt;
    send("\023", 1'b1);
    repeat (10) @(posedge clk);
    respq.push_back(8'h51);
    repeat (30) @(posedge clk);
    chk(qoe_cnt == q0 + 1 && qoe_code === 16'hFE70, "error log");
    chk(sld_host_model_i.got.size() == 0, "halted output");
    chk(resp_ready === 1'b0, "response held");
    send("\021", 1'b1);
    check_tx("Q!");
    $display("flow test done");
    set_cfg(3'b010);
    send("A\010B\015", 1'b0);
    check_tx("A\010 \010B\015");
    check_line("B\015");
    check_tx("\015\012");
    send("\012", 1'b0);
    repeat (20) @(posedge clk);
    chk(lineq.size() == 0 && line_pending === 1'b0, "one line");
    chk(sld_host_model_i.got.size() == 0, "pair not echoed");
    repeat (6) begin
      s = "";
      n = 1 + {$random(seed)} % 12;
      for (int i = 0; i < n; i++) begin
        c = byte'(8'h20 + {$random(seed)} % 95);
        s = {s, string'(c)};
      end
      send(s, 1'b0);
      check_tx(s);
      send("\015", 1'b0);
      check_tx("\015");
      check_line({s, "\015"});
      check_tx("\015\012");
    end
    $display("echo test done");
    set_cfg(3'b000);
    q0 = can_cnt;
    send("XY\001\037\033Z\002\015", 1'b0);
    check_tx("\015\012");
    check_line("Z\015");
    check_tx("\015\012");
    send("AB\030C\015", 1'b0);
    check_line("C\015");
    check_tx("\015\012");
    chk(can_cnt == q0 + 1, "cancel");
    $display("editing test done");
    set_cfg(3'b101);
    send("P\015", 1'b0);
    check_line("P\015");
    check_tx("\023\015\012>\021");
    $display("prompt test done");
    set_cfg(3'b010);
    hold_stall = 1'b1;
    q0 = qoe_cnt;
    send("abcdefghijkl", 1'b0);
    repeat (100) @(posedge clk);
    hold_stall = 1'b0;
    repeat (200) @(posedge clk);
    chk(qoe_cnt > q0, "overflow logged");
    found = 1'b0;
    foreach (sld_host_model_i.got[i])
      if (sld_host_model_i.got[i] === 8'h15) found = 1'b1;
    chk(found, "nak sent");
    sld_host_model_i.got.delete();
    send("\033", 1'b0);
    check_tx("\015\012");
    $display("overflow test done");
    report_and_stop;
  end
endmodule // sld_core_test
